// ### hw/rtz_timer.v
// timer zero control block with shared start/stop register, APB slave
// assumes count ticks, transceiver events and the other timers' underflows
// are one-cycle pulses on pclk; only the oscillator pin is asynchronous
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rtz_consts.vh"

module rtz_timer (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // count sources, one-cycle pulses
    input  wire        tick_fast,
    input  wire        tick_slow,
    input  wire        timer_one_underflow,
    input  wire        timer_two_underflow,
    // transceiver events, one-cycle pulses
    input  wire        tx_end,
    input  wire        rx_first_bits,
    // oscillator pin, asynchronous
    input  wire        low_freq_oscillator,
    // other timers' running state and commands
    input  wire        timer_one_active,
    input  wire        timer_two_active,
    input  wire        timer_three_active,
    output reg  [2:0]  timer_start,
    output reg  [2:0]  timer_stop,
    // timer zero outputs
    output reg         timer_zero_underflow,
    output reg         irq
);

    // ----------------------------------------------------------------
    // address decode helper
    // ----------------------------------------------------------------
    function hit;
        input [7:0] addr;
        input [5:0] idx;
        begin
            hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [7:0]  timer_zero_config;
    reg  [7:0]  timer_zero_reload_high;
    reg  [7:0]  timer_zero_reload_low;
    reg  [15:0] count;
    reg         timer_zero_active;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_mask;
    reg         osc_meta;
    reg         osc_sync;
    reg         osc_prev;

    wire        wr_en;
    wire        rd_en;
    wire        mapped;
    wire [1:0]  mode;
    wire [1:0]  src;
    wire        trimming;
    wire        osc_rise;
    wire [15:0] reload_value;
    wire        wr_run;
    reg         tick;
    reg         next_active;
    reg  [15:0] next_count;
    reg         next_underflow;
    reg         next_auto_start;
    reg  [31:0] next_rdata;

    // transfer completes on the edge that sees pready high
    assign wr_en  = psel & penable & pready & pwrite;
    assign rd_en  = psel & penable & ~pready & ~pwrite;
    assign mapped = hit(paddr, `RTZ_IDX_RUN_CTRL)
                  | hit(paddr, `RTZ_IDX_CONFIG)
                  | hit(paddr, `RTZ_IDX_RELOAD_HIGH)
                  | hit(paddr, `RTZ_IDX_RELOAD_LOW)
                  | hit(paddr, `RTZ_IDX_COUNT_HIGH)
                  | hit(paddr, `RTZ_IDX_COUNT_LOW)
                  | hit(paddr, `RTZ_IDX_IRQ_STATUS)
                  | hit(paddr, `RTZ_IDX_IRQ_MASK);
    assign wr_run = wr_en & hit(paddr, `RTZ_IDX_RUN_CTRL);

    assign mode     = timer_zero_config[`RTZ_CFG_MODE_HI:`RTZ_CFG_MODE_LO];
    assign src      = timer_zero_config[`RTZ_CFG_SRC_HI:`RTZ_CFG_SRC_LO];
    assign trimming = mode[1];
    assign osc_rise = osc_sync & ~osc_prev;
    assign reload_value = {timer_zero_reload_high, timer_zero_reload_low};

    // ----------------------------------------------------------------
    // oscillator pin synchroniser, edge seen only past the second stage
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= low_freq_oscillator;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    always @* begin
        case (src)
            `RTZ_SRC_FAST:      tick = tick_fast;
            `RTZ_SRC_SLOW:      tick = tick_slow;
            `RTZ_SRC_TIMER_TWO: tick = timer_two_underflow;
            default:            tick = timer_one_underflow;
        endcase
    end

    // ----------------------------------------------------------------
    // timer zero next-state: counting first, then events, software last
    // ----------------------------------------------------------------
    always @* begin
        next_active     = timer_zero_active;
        next_count      = count;
        next_underflow  = 1'b0;
        next_auto_start = 1'b0;
        // count down; a tick at one or zero means zero is reached
        if (timer_zero_active && tick) begin
            if (count > 16'h0001) begin
                next_count = count - 16'h0001;
            end else if (mode == `RTZ_MODE_TRIM) begin
                // trimming without underflow parks at zero
                next_count = 16'h0000;
            end else begin
                next_underflow = 1'b1;
                if (timer_zero_config[`RTZ_CFG_AUTO_RELOAD]) begin
                    next_count = reload_value;
                end else begin
                    // stop and drop the running bit
                    next_count  = 16'h0000;
                    next_active = 1'b0;
                end
            end
        end
        // halt after first received bits; not when trimming
        if (timer_zero_config[`RTZ_CFG_STOP_RX] && !trimming
                && rx_first_bits) begin
            next_active = 1'b0;
        end
        if (mode == `RTZ_MODE_TX_END && tx_end) begin
            next_active     = 1'b1;
            next_auto_start = 1'b1;
        end
        // rising oscillator edges alternately start and stop
        if (trimming && osc_rise) begin
            next_active     = ~timer_zero_active;
            next_auto_start = ~timer_zero_active;
        end
        // masked software start or stop of timer zero
        if (wr_run && pwdata[0]) begin
            next_active     = pwdata[4];
            next_auto_start = pwdata[4];
        end
        // every start loads the full reload value
        if (next_auto_start) begin
            next_count = reload_value;
        end
    end

    // ----------------------------------------------------------------
    // timer zero registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_zero_active    <= 1'b0;
            count                <= `RTZ_RST_COUNT;
            timer_zero_underflow <= 1'b0;
        end else begin
            timer_zero_active    <= next_active;
            count                <= next_count;
            timer_zero_underflow <= next_underflow;
        end
    end

    // ----------------------------------------------------------------
    // commands to the other timers, one-cycle pulses
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_start <= 3'h0;
            timer_stop  <= 3'h0;
        end else begin
            // masked bits start or stop timers one to three
            // mask bits 3..1 gate bits 7..5
            if (wr_run) begin
                timer_start <= pwdata[3:1] & pwdata[7:5];
                timer_stop  <= pwdata[3:1] & ~pwdata[7:5];
            end else begin
                timer_start <= 3'h0;
                timer_stop  <= 3'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_zero_config      <= `RTZ_RST_BYTE;
            timer_zero_reload_high <= `RTZ_RST_BYTE;
            timer_zero_reload_low  <= `RTZ_RST_BYTE;
            irq_mask               <= 2'h0;
        end else if (wr_en) begin
            if (hit(paddr, `RTZ_IDX_CONFIG)) begin
                timer_zero_config <= pwdata[7:0] & `RTZ_CFG_WRITE_MASK;
            end
            // reload bytes reach the counter only on a start or an auto-reload underflow
            if (hit(paddr, `RTZ_IDX_RELOAD_HIGH)) begin
                timer_zero_reload_high <= pwdata[7:0];
            end
            if (hit(paddr, `RTZ_IDX_RELOAD_LOW)) begin
                timer_zero_reload_low <= pwdata[7:0];
            end
            if (hit(paddr, `RTZ_IDX_IRQ_MASK)) begin
                irq_mask <= pwdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky status, a new event beats a same-cycle clear
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
            irq        <= 1'b0;
        end else begin
            // underflow flag sticks until written with one
            irq_status <= (irq_status
                          & ~((wr_en && hit(paddr, `RTZ_IDX_IRQ_STATUS))
                              ? pwdata[1:0] : 2'h0))
                        | {next_auto_start & ~timer_zero_active,
                           next_underflow};
            irq <= |(next_irq_status_masked(irq_status, irq_mask));
        end
    end

    // irq lags status by one cycle so that the pin is a flip-flop
    function [1:0] next_irq_status_masked;
        input [1:0] status;
        input [1:0] mask;
        begin
            next_irq_status_masked = status & mask;
        end
    endfunction

    // ----------------------------------------------------------------
    // read mux; counter bytes are live and may tear during reception
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit(paddr, `RTZ_IDX_RUN_CTRL)) begin
            // mask bits read back as zero
            next_rdata[7:0] = {timer_three_active, timer_two_active,
                               timer_one_active, timer_zero_active, 4'h0};
        end else if (hit(paddr, `RTZ_IDX_CONFIG)) begin
            next_rdata[7:0] = timer_zero_config;
        end else if (hit(paddr, `RTZ_IDX_RELOAD_HIGH)) begin
            next_rdata[7:0] = timer_zero_reload_high;
        end else if (hit(paddr, `RTZ_IDX_RELOAD_LOW)) begin
            next_rdata[7:0] = timer_zero_reload_low;
        end else if (hit(paddr, `RTZ_IDX_COUNT_HIGH)) begin
            next_rdata[7:0] = count[15:8];
        end else if (hit(paddr, `RTZ_IDX_COUNT_LOW)) begin
            next_rdata[7:0] = count[7:0];
        end else if (hit(paddr, `RTZ_IDX_IRQ_STATUS)) begin
            next_rdata[1:0] = irq_status;
        end else if (hit(paddr, `RTZ_IDX_IRQ_MASK)) begin
            next_rdata[1:0] = irq_mask;
        end
    end

    // ----------------------------------------------------------------
    // apb handshake, one wait state so every answer is registered
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (rd_en) begin
                prdata <= next_rdata;
            end
        end
    end

endmodule

`default_nettype wire

// ### hw/rtz_consts.vh
// constants for the timer zero control block: register indices, field
// positions, reset values and mode encodings
// assumes a byte-addressed 32-bit register bus, one word per register
//
// Operation
// - masked write updates only enabled running bits
// - bits 7..4 show and start/stop timers
// - low four bits are write-only masks
// - stop after first four received bits
// - trimming modes ignore stop-on-receive
// - start mode 00 none, 01 after transmission
// - modes 10/11 trimming, started/stopped on rising edges
// - auto reload restarts count at zero; mode 10 parks the count at zero instead
// - without auto reload stop at zero; mode 10 parks at zero and keeps running
// - underflow sets the interrupt request flag
// - clock select picks the count source
// - every start loads the reload value
// - reload writes wait for next start or auto reload
`ifndef RTZ_CONSTS_VH
`define RTZ_CONSTS_VH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define RTZ_IDX_RUN_CTRL    6'h0E
`define RTZ_IDX_CONFIG      6'h0F
`define RTZ_IDX_RELOAD_HIGH 6'h10
`define RTZ_IDX_RELOAD_LOW  6'h11
`define RTZ_IDX_COUNT_HIGH  6'h12
`define RTZ_IDX_COUNT_LOW   6'h13
`define RTZ_IDX_IRQ_STATUS  6'h20
`define RTZ_IDX_IRQ_MASK    6'h21

// ----------------------------------------------------------------
// field positions of the timer zero config register
// ----------------------------------------------------------------
`define RTZ_CFG_STOP_RX     7
`define RTZ_CFG_MODE_HI     5
`define RTZ_CFG_MODE_LO     4
`define RTZ_CFG_AUTO_RELOAD 3
`define RTZ_CFG_SRC_HI      1
`define RTZ_CFG_SRC_LO      0
`define RTZ_CFG_WRITE_MASK  8'hBB

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define RTZ_MODE_NONE       2'h0
`define RTZ_MODE_TX_END     2'h1
`define RTZ_MODE_TRIM       2'h2
`define RTZ_MODE_TRIM_UF    2'h3
`define RTZ_SRC_FAST        2'h0
`define RTZ_SRC_SLOW        2'h1
`define RTZ_SRC_TIMER_TWO   2'h2
`define RTZ_SRC_TIMER_ONE   2'h3

// ----------------------------------------------------------------
// interrupt status bits and reset values
// ----------------------------------------------------------------
`define RTZ_IRQ_UNDERFLOW   0
`define RTZ_IRQ_AUTO_START  1
`define RTZ_RST_BYTE        8'h00
`define RTZ_RST_COUNT       16'h0000

`endif

// ### verification/rtz_timer_chk.sv
// concurrent checks on the ports of the timer zero control block
// assumes one clock domain and the register indices of rtz_consts.vh
`timescale 1ns/1ps
`default_nettype none
`include "rtz_consts.vh"

module rtz_timer_chk (
    // clock, reset and apb
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        pready, pslverr,
    // count sources and transceiver events
    input wire logic        tick_fast, tick_slow, tx_end, rx_first_bits,
    input wire logic        timer_one_underflow, timer_two_underflow,
    input wire logic        low_freq_oscillator, timer_one_active,
    input wire logic        timer_two_active, timer_three_active,
    // timer commands and outputs
    input wire logic [2:0]  timer_start, timer_stop,
    input wire logic        timer_zero_underflow, irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // completed write to the shared start/stop register
    wire run_wr = psel && penable && pready && pwrite
                  && paddr == {`RTZ_IDX_RUN_CTRL, 2'h0};
    // any count pulse; the clock select may pick any one of them
    wire any_tick = tick_fast || tick_slow || timer_one_underflow
                    || timer_two_underflow;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_apb_wait_state: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after the wait state");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_refused_read: assert property (pslverr |-> pready
                                       && (pwrite || prdata == 32'h0))
        else $error("pslverr without pready or with read data");
    chk_mask_start: assert property (run_wr && pwdata[1] && pwdata[5]
                                     |=> timer_start[0] && !timer_stop[0])
        else $error("masked start of timer one not issued");
    chk_mask_stop: assert property (run_wr && pwdata[1] && !pwdata[5]
                                    |=> timer_stop[0] && !timer_start[0])
        else $error("masked stop of timer one not issued");
    chk_mask_hold: assert property (run_wr && !pwdata[3]
                                    |=> !timer_start[2] && !timer_stop[2])
        else $error("timer three commanded without its mask bit");
    chk_underflow_pulse: assert property (timer_zero_underflow
                                          |=> !timer_zero_underflow)
        else $error("underflow pulse longer than one cycle");
    chk_underflow_cause: assert property (timer_zero_underflow
                                          |-> $past(any_tick))
        else $error("underflow without a count pulse");

    cov_underflow: cover property (timer_zero_underflow);
    cov_irq: cover property ($rose(irq));
    cov_refused: cover property (pslverr);
endmodule

bind rtz_timer rtz_timer_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_fast(tick_fast), .tick_slow(tick_slow), .tx_end(tx_end),
    .rx_first_bits(rx_first_bits), .timer_one_underflow(timer_one_underflow),
    .timer_two_underflow(timer_two_underflow),
    .low_freq_oscillator(low_freq_oscillator),
    .timer_one_active(timer_one_active), .timer_two_active(timer_two_active),
    .timer_three_active(timer_three_active), .timer_start(timer_start),
    .timer_stop(timer_stop), .timer_zero_underflow(timer_zero_underflow),
    .irq(irq));
`default_nettype wire

// ### verification/rtz_timer_tb.sv
// directed bench for the timer zero control block over apb
// assumes rtz_timer and its checker; events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "rtz_consts.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fails++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module rtz_timer_tb;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0;
    logic        penable = 1'h0, pwrite = 1'h0, osc = 1'h0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [5:0]  ev = 6'h00;
    logic [2:0]  act = 3'h5;
    wire  [31:0] prdata;
    wire  [2:0]  t_start, t_stop;
    wire         pready, pslverr, uf, irq;
    int          fails = 0, checks_done = 0, uf_seen = 0;
    int          st_seen = 0, sp_seen = 0;

    initial forever #10 pclk = ~pclk;

    // ev bit equals the count source code; bits 4, 5 are tx and rx events
    rtz_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tick_fast(ev[0]), .tick_slow(ev[1]), .timer_one_underflow(ev[3]),
        .timer_two_underflow(ev[2]), .tx_end(ev[4]), .rx_first_bits(ev[5]),
        .low_freq_oscillator(osc), .timer_one_active(act[0]),
        .timer_two_active(act[1]), .timer_three_active(act[2]),
        .timer_start(t_start), .timer_stop(t_stop),
        .timer_zero_underflow(uf), .irq(irq));

    // count underflow pulses as the design presents them
    always @(posedge pclk) if (uf === 1'h1) uf_seen++;
    // count start and stop commands to timer one
    always @(posedge pclk) if (t_start[0] === 1'h1) st_seen++;
    always @(posedge pclk) if (t_stop[0] === 1'h1) sp_seen++;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [5:0] idx, input logic w,
                       input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) fails++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        apb(idx, 1'h1, v);
    endtask
    task automatic expect_reg(input logic [5:0] idx, input logic [7:0] e,
                              input string nm);
        apb(idx, 1'h0, 8'h00);
        `CHK(nm, {24'h0, e}, rd)
    endtask
    task automatic pulse(input int b);
        @(posedge pclk);
        ev <= 6'h01 << b;
        @(posedge pclk);
        ev <= 6'h00;
    endtask
    // slow pin change, left long enough for the synchroniser
    task automatic osc_to(input logic v);
        @(posedge pclk);
        osc <= v;
        repeat (6) @(posedge pclk);
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        expect_reg(`RTZ_IDX_RELOAD_LOW, 8'h00, "reload");
        wr(`RTZ_IDX_CONFIG, 8'hFF);
        expect_reg(`RTZ_IDX_CONFIG, 8'hBB, "config");
        wr(`RTZ_IDX_RUN_CTRL, 8'hF0);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hA0, "run");
        wr(`RTZ_IDX_RUN_CTRL, 8'h22);
        wr(`RTZ_IDX_RUN_CTRL, 8'h02);
        `CHK("starts", 1, st_seen)
        // software start, count down, stop at zero
        wr(`RTZ_IDX_CONFIG, 8'h00);
        `CHK("stops", 1, sp_seen)
        wr(`RTZ_IDX_RELOAD_LOW, 8'h03);
        wr(`RTZ_IDX_RUN_CTRL, 8'h11);
        pulse(0);
        expect_reg(`RTZ_IDX_COUNT_LOW, 8'h02, "count");
        pulse(0);
        pulse(0);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hA0, "run");
        `CHK("underflows", 1, uf_seen)
        apb(`RTZ_IDX_IRQ_STATUS, 1'h0, 8'h00);
        `CHK("flag", 1'h1, rd[0])
        // irq masked, unmasked, then cleared
        `CHK("irq", 1'h0, irq)
        wr(`RTZ_IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'h1, irq)
        wr(`RTZ_IDX_IRQ_STATUS, 8'h03);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'h0, irq)
        // reload written mid-count waits for the next start
        wr(`RTZ_IDX_RELOAD_LOW, 8'h05);
        wr(`RTZ_IDX_RUN_CTRL, 8'h11);
        pulse(0);
        wr(`RTZ_IDX_RELOAD_LOW, 8'h09);
        expect_reg(`RTZ_IDX_COUNT_LOW, 8'h04, "count");
        wr(`RTZ_IDX_RUN_CTRL, 8'h01);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hA0, "run");
        wr(`RTZ_IDX_RUN_CTRL, 8'h11);
        expect_reg(`RTZ_IDX_COUNT_LOW, 8'h09, "count");
        wr(`RTZ_IDX_RUN_CTRL, 8'h01);
        // auto reload keeps the timer running
        wr(`RTZ_IDX_CONFIG, 8'h08);
        wr(`RTZ_IDX_RELOAD_LOW, 8'h02);
        wr(`RTZ_IDX_RUN_CTRL, 8'h11);
        pulse(0);
        pulse(0);
        expect_reg(`RTZ_IDX_COUNT_LOW, 8'h02, "count");
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hB0, "run");
        wr(`RTZ_IDX_RUN_CTRL, 8'h01);
        // start on transmission end, stop on first received bits
        wr(`RTZ_IDX_CONFIG, 8'h90);
        pulse(4);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hB0, "run");
        pulse(5);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hA0, "run");
        wr(`RTZ_IDX_CONFIG, 8'h00);
        pulse(4);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hA0, "run");
        // trimming without underflow ignores the receive stop
        wr(`RTZ_IDX_RELOAD_LOW, 8'h01);
        wr(`RTZ_IDX_CONFIG, 8'hA0);
        osc_to(1'h1);
        pulse(0);
        pulse(5);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hB0, "run");
        `CHK("underflows", 2, uf_seen)
        osc_to(1'h0);
        osc_to(1'h1);
        expect_reg(`RTZ_IDX_RUN_CTRL, 8'hA0, "run");
        // trimming with underflow
        wr(`RTZ_IDX_CONFIG, 8'h30);
        osc_to(1'h0);
        osc_to(1'h1);
        pulse(0);
        repeat (2) @(posedge pclk);
        `CHK("underflows", 3, uf_seen)
        wr(`RTZ_IDX_CONFIG, 8'h00);
        wr(`RTZ_IDX_RUN_CTRL, 8'h01);
        // every count source, one underflow each; with a reload of one an unselected pulse that counted would leave the total unchanged
        for (int s = 0; s < 4; s++) begin
            wr(`RTZ_IDX_CONFIG, 8'(s));
            wr(`RTZ_IDX_RUN_CTRL, 8'h11);
            pulse((s + 1) % 4);
            pulse(s);
            repeat (2) @(posedge pclk);
            `CHK("underflows", 4 + s, uf_seen)
        end
        // unmapped address is refused
        apb(6'h01, 1'h0, 8'h00);
        `CHK("slverr", 1'h1, err)
        `CHK("rdata", 32'h0, rd)
        summarize();
    end

    // watchdog, far beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        summarize();
    end
endmodule
`default_nettype wire
